// >>> logic/pviu_consts.vh
// Constants of the prioritized vectored interrupt unit
`ifndef PVIU_CONSTS_VH
`define PVIU_CONSTS_VH

// Register offsets
`define PVIU_OFS_EXT0_CTRL   8'h98
`define PVIU_OFS_EXT1_CTRL   8'h99
`define PVIU_OFS_EXT_BASE    8'h9A
`define PVIU_OFS_INT_BASE    8'h9B
`define PVIU_OFS_PRI_STACK   8'h9C
`define PVIU_OFS_PENDING     8'h9D

// Reset values
`define PVIU_RST_CTRL        8'h00
`define PVIU_RST_BASE        8'h00
`define PVIU_RST_PRI_STACK   8'h00

// External control register fields
`define PVIU_PRI_HI          1
`define PVIU_PRI_LO          0
`define PVIU_PINA_HI         3
`define PVIU_PINA_LO         2
`define PVIU_PINB_HI         5
`define PVIU_PINB_LO         4
`define PVIU_CTRL_USED       8'h3F

// Source indices in fixed service order, first wins on a tie
`define PVIU_SRC_EXT1        4'h0
`define PVIU_SRC_EXT0        4'h1
`define PVIU_SRC_PERIODIC    4'h2
`define PVIU_SRC_TIMERB      4'h3
`define PVIU_SRC_TIMERA      4'h4
`define PVIU_SRC_SLAVE       4'h5
`define PVIU_SRC_SERA        4'h6
`define PVIU_SRC_SERB        4'h7
`define PVIU_SRC_SERC        4'h8
`define PVIU_SRC_SERD        4'h9
`define PVIU_NUM_SRC         10

// Catchers kept when an external is taken: {ext1B, ext0B, ext1A, ext0A}
`define PVIU_KEEP_EXT0       4'hA
`define PVIU_KEEP_EXT1       4'h5

// Fixed vector low bytes
`define PVIU_LOW_EXT0        8'h00
`define PVIU_LOW_EXT1        8'h10
`define PVIU_LOW_PERIODIC    8'h00
`define PVIU_LOW_SLAVE       8'h80
`define PVIU_LOW_TIMERA      8'hA0
`define PVIU_LOW_TIMERB      8'hB0
`define PVIU_LOW_SERA        8'hC0
`define PVIU_LOW_SERB        8'hD0
`define PVIU_LOW_SERC        8'hE0
`define PVIU_LOW_SERD        8'hF0
`define PVIU_LOW_RST10       8'h20
`define PVIU_LOW_RST18       8'h30
`define PVIU_LOW_RST20       8'h40
`define PVIU_LOW_RST28       8'h50
`define PVIU_LOW_RST38       8'h70

`endif

// >>> logic/pviu_top.v
// Prioritized vectored interrupt unit: arbitration, vectors, edge catchers
`timescale 1ns/10ps
`include "pviu_consts.vh"

module pviu_top (
	input  wire        clk_sys,
	input  wire        rst,
	input  wire [7:0]  reg_addr,
	input  wire [7:0]  reg_wdata,
	input  wire        reg_wr,
	input  wire        reg_rd,
	output reg  [7:0]  reg_rdata,
	input  wire        porte_bit0,
	input  wire        porte_bit1,
	input  wire        porte_bit4,
	input  wire        porte_bit5,
	input  wire        periodic_req,
	input  wire [1:0]  periodic_pri,
	input  wire        timerb_req,
	input  wire [1:0]  timerb_pri,
	input  wire        timera_req,
	input  wire [1:0]  timera_pri,
	input  wire        slave_req,
	input  wire [1:0]  slave_pri,
	input  wire [3:0]  serial_req,
	input  wire [7:0]  serial_pri,
	input  wire        cpu_instr_end,
	input  wire        cpu_pri_restore,
	input  wire [2:0]  cpu_rst_sel,
	output wire [15:0] cpu_rst_vector,
	output reg         int_call,
	output reg  [15:0] int_vector,
	output reg  [3:0]  int_source,
	output wire [1:0]  cpu_priority
);

	// Pin order inside the catcher vectors: {bit5, bit4, bit1, bit0}
	localparam NPIN = 4;

	reg  [7:0]      ext0_control_reg;
	reg  [7:0]      ext1_control_reg;
	reg  [7:0]      external_vector_base_reg;
	reg  [7:0]      internal_vector_base_reg;
	reg  [7:0]      priority_stack_register_reg;
	reg  [7:0]      priority_stack_next;
	reg  [NPIN-1:0] pin_s1_reg;
	reg  [NPIN-1:0] pin_s2_reg;
	reg  [NPIN-1:0] pin_s3_reg;
	reg  [NPIN-1:0] pin_level_reg;
	reg  [NPIN-1:0] catch_reg;
	reg  [NPIN-1:0] catch_next;
	reg  [NPIN-1:0] rise;
	reg  [NPIN-1:0] fall;
	reg  [NPIN-1:0] hit;
	wire [NPIN-1:0] pin_in;
	wire            external_request_zero;
	wire            external_request_one;
	reg  [`PVIU_NUM_SRC-1:0] src_req;
	reg  [1:0]      src_pri [0:`PVIU_NUM_SRC-1];
	reg  [1:0]      best_pri;
	reg  [3:0]      best_src;
	reg             best_found;
	reg  [7:0]      rdata_next;
	wire            take_now;
	wire            wr_stack;
	integer         i;
	integer         j;

	// Edge enable test on a two-bit field: bit 1 rising, bit 0 falling
	function edge_hit;
		input [1:0] field;
		input       r;
		input       f;
		begin
			edge_hit = (field[1] & r) | (field[0] & f);
		end
	endfunction

	// Fixed low byte of each source
	function [7:0] low_byte;
		input [3:0] src;
		begin
			case (src)
			`PVIU_SRC_EXT1:     low_byte = `PVIU_LOW_EXT1;
			`PVIU_SRC_EXT0:     low_byte = `PVIU_LOW_EXT0;
			`PVIU_SRC_PERIODIC: low_byte = `PVIU_LOW_PERIODIC;
			`PVIU_SRC_TIMERB:   low_byte = `PVIU_LOW_TIMERB;
			`PVIU_SRC_TIMERA:   low_byte = `PVIU_LOW_TIMERA;
			`PVIU_SRC_SLAVE:    low_byte = `PVIU_LOW_SLAVE;
			`PVIU_SRC_SERA:     low_byte = `PVIU_LOW_SERA;
			`PVIU_SRC_SERB:     low_byte = `PVIU_LOW_SERB;
			`PVIU_SRC_SERC:     low_byte = `PVIU_LOW_SERC;
			default:            low_byte = `PVIU_LOW_SERD;
			endcase
		end
	endfunction

	assign pin_in = {porte_bit5, porte_bit4, porte_bit1, porte_bit0};
	assign cpu_priority = priority_stack_register_reg[1:0];

	// Restart instructions share the internal base table
	function [7:0] rst_low;
		input [2:0] sel;
		begin
			case (sel)
			3'h0:    rst_low = `PVIU_LOW_RST10;
			3'h1:    rst_low = `PVIU_LOW_RST18;
			3'h2:    rst_low = `PVIU_LOW_RST20;
			3'h3:    rst_low = `PVIU_LOW_RST28;
			default: rst_low = `PVIU_LOW_RST38;
			endcase
		end
	endfunction

	assign cpu_rst_vector = {internal_vector_base_reg,
		rst_low(cpu_rst_sel)};

	// Externals draw their high byte from their own base register
	function is_ext;
		input [3:0] src;
		begin
			is_ext = (src == `PVIU_SRC_EXT0) ||
				(src == `PVIU_SRC_EXT1);
		end
	endfunction

	// Catchers kept by a take: only the taken external loses its pair
	function [NPIN-1:0] keep_mask;
		input [3:0] src;
		begin
			case (src)
			`PVIU_SRC_EXT0: keep_mask = `PVIU_KEEP_EXT0;
			`PVIU_SRC_EXT1: keep_mask = `PVIU_KEEP_EXT1;
			default:        keep_mask = {NPIN{1'b1}};
			endcase
		end
	endfunction

	// Pop copies the top pair down, so an emptied stack stays defined
	function [7:0] stack_pop;
		input [7:0] stk;
		begin
			stack_pop = {stk[7:6], stk[7:2]};
		end
	endfunction

	function [7:0] stack_push;
		input [7:0] stk;
		input [1:0] pri;
		begin
			stack_push = {stk[5:0], pri};
		end
	endfunction

	// Pins are asynchronous; a change counts once stages two and three agree.
	// Port pins driven by software come back through the same input path.
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			pin_s1_reg    <= {NPIN{1'b0}};
			pin_s2_reg    <= {NPIN{1'b0}};
			pin_s3_reg    <= {NPIN{1'b0}};
			pin_level_reg <= {NPIN{1'b0}};
		end else begin
			pin_s1_reg <= pin_in;
			pin_s2_reg <= pin_s1_reg;
			pin_s3_reg <= pin_s2_reg;
			for (i = 0; i < NPIN; i = i + 1) begin
				if (pin_s2_reg[i] == pin_s3_reg[i])
					pin_level_reg[i] <= pin_s3_reg[i];
			end
		end
	end

	// Edge detection per pin with the field of its own catcher
	always @* begin
		rise = pin_s3_reg & ~pin_level_reg & (pin_s2_reg ~^ pin_s3_reg);
		fall = ~pin_s3_reg & pin_level_reg & (pin_s2_reg ~^ pin_s3_reg);
		hit[0] = edge_hit(ext0_control_reg[`PVIU_PINA_HI:`PVIU_PINA_LO],
			rise[0], fall[0]);
		hit[1] = edge_hit(ext1_control_reg[`PVIU_PINA_HI:`PVIU_PINA_LO],
			rise[1], fall[1]);
		hit[2] = edge_hit(ext0_control_reg[`PVIU_PINB_HI:`PVIU_PINB_LO],
			rise[2], fall[2]);
		hit[3] = edge_hit(ext1_control_reg[`PVIU_PINB_HI:`PVIU_PINB_LO],
			rise[3], fall[3]);
	end

	// Two catchers share one request; either one raises it
	assign external_request_zero = catch_reg[0] | catch_reg[2];
	assign external_request_one  = catch_reg[1] | catch_reg[3];

	// Source table in fixed service order
	always @* begin
		src_req[`PVIU_SRC_EXT1]     = external_request_one;
		src_pri[`PVIU_SRC_EXT1]     = ext1_control_reg[`PVIU_PRI_HI:
			`PVIU_PRI_LO];
		src_req[`PVIU_SRC_EXT0]     = external_request_zero;
		src_pri[`PVIU_SRC_EXT0]     = ext0_control_reg[`PVIU_PRI_HI:
			`PVIU_PRI_LO];
		// Peripheral latches are levels; each source drops its own
		src_req[`PVIU_SRC_PERIODIC] = periodic_req;
		src_pri[`PVIU_SRC_PERIODIC] = periodic_pri;
		src_req[`PVIU_SRC_TIMERB]   = timerb_req;
		src_pri[`PVIU_SRC_TIMERB]   = timerb_pri;
		src_req[`PVIU_SRC_TIMERA]   = timera_req;
		src_pri[`PVIU_SRC_TIMERA]   = timera_pri;
		src_req[`PVIU_SRC_SLAVE]    = slave_req;
		src_pri[`PVIU_SRC_SLAVE]    = slave_pri;
		src_req[`PVIU_SRC_SERA]     = serial_req[0];
		src_pri[`PVIU_SRC_SERA]     = serial_pri[1:0];
		src_req[`PVIU_SRC_SERB]     = serial_req[1];
		src_pri[`PVIU_SRC_SERB]     = serial_pri[3:2];
		src_req[`PVIU_SRC_SERC]     = serial_req[2];
		src_pri[`PVIU_SRC_SERC]     = serial_pri[5:4];
		src_req[`PVIU_SRC_SERD]     = serial_req[3];
		src_pri[`PVIU_SRC_SERD]     = serial_pri[7:6];
	end

	// Arbiter: starting from the current priority, only a strictly higher
	// level replaces the pick, so the earlier source keeps a tie.
	// A priority of zero never beats anything, which disables the source.
	always @* begin
		best_pri   = priority_stack_register_reg[1:0];
		best_src   = `PVIU_SRC_EXT1;
		best_found = 1'b0;
		for (j = 0; j < `PVIU_NUM_SRC; j = j + 1) begin
			if (src_req[j] && src_pri[j] > best_pri) begin
				best_pri   = src_pri[j];
				best_src   = j[3:0];
				best_found = 1'b1;
			end
		end
	end

	// A take needs an instruction boundary and a winning request
	assign take_now = cpu_instr_end & best_found;
	assign wr_stack = reg_wr && (reg_addr == `PVIU_OFS_PRI_STACK);

	// Priority stack: restore pops first, then a take pushes; a software
	// write of the same cycle beats both
	always @* begin
		priority_stack_next = priority_stack_register_reg;
		if (cpu_pri_restore)
			priority_stack_next = stack_pop(priority_stack_next);
		if (take_now)
			priority_stack_next = stack_push(priority_stack_next,
				best_pri);
		if (wr_stack)
			priority_stack_next = reg_wdata;
	end

	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			priority_stack_register_reg <= `PVIU_RST_PRI_STACK;
		end else begin
			priority_stack_register_reg <= priority_stack_next;
		end
	end

	// Catchers: a new edge outweighs the clear of the same cycle, so an
	// edge arriving at the take is not lost
	always @* begin
		catch_next = catch_reg;
		if (take_now)
			catch_next = catch_next & keep_mask(best_src);
		catch_next = catch_next | hit;
	end

	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			catch_reg <= {NPIN{1'b0}};
		end else begin
			catch_reg <= catch_next;
		end
	end

	// Interrupt take, latched only at an instruction boundary
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			int_call   <= 1'b0;
			int_vector <= 16'h0000;
			int_source <= 4'h0;
		end else begin
			int_call <= take_now;
			// A request withdrawn before this edge is simply not seen
			if (take_now) begin
				int_source <= best_src;
				if (is_ext(best_src))
					int_vector <= {external_vector_base_reg,
						low_byte(best_src)};
				else
					int_vector <= {internal_vector_base_reg,
						low_byte(best_src)};
			end
		end
	end

	// Register writes; unused control bits are dropped so they read 0
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			ext0_control_reg <= `PVIU_RST_CTRL;
		end else if (reg_wr && reg_addr == `PVIU_OFS_EXT0_CTRL) begin
			ext0_control_reg <= reg_wdata & `PVIU_CTRL_USED;
		end
	end

	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			ext1_control_reg <= `PVIU_RST_CTRL;
		end else if (reg_wr && reg_addr == `PVIU_OFS_EXT1_CTRL) begin
			ext1_control_reg <= reg_wdata & `PVIU_CTRL_USED;
		end
	end

	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			external_vector_base_reg <= `PVIU_RST_BASE;
		end else if (reg_wr && reg_addr == `PVIU_OFS_EXT_BASE) begin
			external_vector_base_reg <= reg_wdata;
		end
	end

	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			internal_vector_base_reg <= `PVIU_RST_BASE;
		end else if (reg_wr && reg_addr == `PVIU_OFS_INT_BASE) begin
			internal_vector_base_reg <= reg_wdata;
		end
	end

	// Register reads; pending view has no side effect on the catchers
	always @* begin
		case (reg_addr)
		`PVIU_OFS_EXT0_CTRL: rdata_next = ext0_control_reg;
		`PVIU_OFS_EXT1_CTRL: rdata_next = ext1_control_reg;
		`PVIU_OFS_EXT_BASE:  rdata_next = external_vector_base_reg;
		`PVIU_OFS_INT_BASE:  rdata_next = internal_vector_base_reg;
		`PVIU_OFS_PRI_STACK: rdata_next = priority_stack_register_reg;
		`PVIU_OFS_PENDING:   rdata_next = {4'h0, catch_reg};
		default:             rdata_next = 8'h00;
		endcase
	end

	always @(posedge clk_sys or posedge rst) begin
		if (rst)
			reg_rdata <= 8'h00;
		else if (reg_rd)
			reg_rdata <= rdata_next;
		else
			reg_rdata <= 8'h00;
	end

endmodule

// >>> tb/pviu_chk.sv
// Concurrent checks on the ports of the interrupt unit
`timescale 1ns/10ps
module pviu_chk (
	input wire logic        clk_sys,
	input wire logic        rst,
	input wire logic        reg_wr,
	input wire logic        cpu_instr_end,
	input wire logic [2:0]  cpu_rst_sel,
	input wire logic [15:0] cpu_rst_vector,
	input wire logic        int_call,
	input wire logic [15:0] int_vector,
	input wire logic [3:0]  int_source,
	input wire logic [1:0]  cpu_priority
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	sequence s_take;
		cpu_instr_end ##1 int_call;
	endsequence
	a_call_one_pulse: assert property (s_take |=> !int_call)
		else $error("call pulse too long");
	a_call_at_end: assert property (int_call |-> $past(cpu_instr_end))
		else $error("call without boundary");
	a_pri_raised: assert property (int_call && !$past(reg_wr) |->
		cpu_priority > $past(cpu_priority)) else $error("priority not raised");
	a_ext1_low: assert property (int_call && int_source == 4'h0 |->
		int_vector[7:0] == 8'h10) else $error("bad ext1 vector");
	a_ext0_low: assert property (int_call && int_source == 4'h1 |->
		int_vector[7:0] == 8'h00) else $error("bad ext0 vector");
	a_int_high: assert property (int_call && int_source > 4'h1 &&
		!$past(reg_wr) |-> int_vector[15:8] == cpu_rst_vector[15:8])
		else $error("bad internal high byte");
	a_timerb_low: assert property (int_call && int_source == 4'h3 |->
		int_vector[7:0] == 8'hB0) else $error("bad timer vector");
	a_vec_hold: assert property (!int_call |-> $stable(int_vector))
		else $error("vector moved without call");
	a_rst_low: assert property (cpu_rst_sel == 3'h0 |->
		cpu_rst_vector[7:0] == 8'h20) else $error("bad restart vector");
endmodule
bind pviu_top pviu_chk u_chk (.clk_sys, .rst, .reg_wr, .cpu_instr_end,
	.cpu_rst_sel, .cpu_rst_vector, .int_call, .int_vector, .int_source,
	.cpu_priority);

// >>> tb/pviu_core_model.sv
// Behavioural core: instruction boundaries, restores, call counting
`timescale 1ns/10ps
module pviu_core_model (
	input  wire logic clk_sys,
	input  wire logic rst,
	input  wire logic step,
	input  wire logic restore,
	input  wire logic int_call,
	output logic      cpu_instr_end = 1'h0,
	output logic      cpu_pri_restore = 1'h0,
	output int        calls = 0
);
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			cpu_instr_end <= 1'h0;
			cpu_pri_restore <= 1'h0;
		end else begin
			cpu_instr_end <= step;
			cpu_pri_restore <= restore;
		end
	end
	// Each call stands for a push of the return address and a jump
	always @(posedge clk_sys) if (int_call) calls <= calls + 1;
endmodule

// >>> tb/pviu_top_tb.sv
// Self-checking bench of the interrupt unit
`timescale 1ns/10ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin err_count++; \
	$display("unexpected at %0t: got %h exp %h", $time, (a), (e)); end end
module pviu_top_tb;
	logic        clk_sys = 0, rst = 1, reg_wr = 0, reg_rd = 0, int_call;
	logic        step = 0, restore = 0, cpu_instr_end, cpu_pri_restore;
	logic        porte_bit0 = 0, porte_bit1 = 1, porte_bit4 = 0;
	logic        porte_bit5 = 0;
	logic [7:0]  reg_addr = 0, reg_wdata = 0, reg_rdata, rq = 0;
	logic [15:0] pv = 0, cpu_rst_vector, int_vector;
	logic [2:0]  cpu_rst_sel = 0;
	logic [3:0]  int_source;
	logic [1:0]  cpu_priority;
	logic [7:0]  lo [8] = '{8'h00, 8'hB0, 8'hA0, 8'h80, 8'hC0, 8'hD0,
		8'hE0, 8'hF0};
	logic [7:0]  rl [5] = '{8'h20, 8'h30, 8'h40, 8'h50, 8'h70};
	int          err_count = 0, cmp_count = 0, calls, i;
	always #2.5 clk_sys = ~clk_sys;
	pviu_top u_dut (.clk_sys, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .porte_bit0, .porte_bit1, .porte_bit4, .porte_bit5,
		.periodic_req(rq[0]), .periodic_pri(pv[1:0]), .timerb_req(rq[1]),
		.timerb_pri(pv[3:2]), .timera_req(rq[2]), .timera_pri(pv[5:4]),
		.slave_req(rq[3]), .slave_pri(pv[7:6]), .serial_req(rq[7:4]),
		.serial_pri(pv[15:8]), .cpu_instr_end, .cpu_pri_restore,
		.cpu_rst_sel, .cpu_rst_vector, .int_call, .int_vector, .int_source,
		.cpu_priority);
	pviu_core_model u_core (.clk_sys, .rst, .step, .restore, .int_call,
		.cpu_instr_end, .cpu_pri_restore, .calls);
	task end_sim;
		$display("compares %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys) begin reg_addr <= a; reg_wdata <= d; reg_wr <= 1; end
		@(posedge clk_sys) reg_wr <= 0;
	endtask
	task rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk_sys) begin reg_addr <= a; reg_rd <= 1; end
		@(posedge clk_sys) reg_rd <= 0;
		#1 `CHK(reg_rdata, e)
	endtask
	// Fixed wait: call lands one cycle after the sampled boundary
	task take(input logic en, input logic [3:0] s, input logic [15:0] v);
		int c;
		c = calls;
		@(posedge clk_sys) step <= 1;
		@(posedge clk_sys) step <= 0;
		repeat (3) @(posedge clk_sys);
		#1 `CHK(calls - c, int'(en))
		if (en) begin
			`CHK(int_source, s)
			`CHK(int_vector, v)
		end
	endtask
	task pop;
		@(posedge clk_sys) restore <= 1;
		@(posedge clk_sys) restore <= 0;
		repeat (2) @(posedge clk_sys);
	endtask
	initial begin
		#20000;
		err_count++;
		end_sim;
	end
	initial begin
		repeat (8) @(posedge clk_sys);
		rst <= 0;
		for (i = 0; i < 6; i++) rd(8'h98 + i[7:0], 8'h00);
		wr(8'h98, 8'hFF);
		rd(8'h98, 8'h3F);
		wr(8'h9D, 8'hFF);
		rd(8'h9D, 8'h00);
		rd(8'hA0, 8'h00);
		wr(8'h98, 8'h00);
		wr(8'h9A, 8'h12);
		wr(8'h9B, 8'h34);
		for (i = 0; i < 5; i++) begin
			@(posedge clk_sys) cpu_rst_sel <= i[2:0];
			#1 `CHK(cpu_rst_vector, {8'h34, rl[i]})
		end
		$display("test registers done");
		// All internal sources pending at one level: fixed order decides
		pv <= 16'h5555;
		rq <= 8'hFF;
		for (i = 0; i < 8; i++) begin
			take(1, 4'h2 + i[3:0], {8'h34, lo[i]});
			rq[i] <= 0;
			pop;
		end
		$display("test order done");
		pv <= 16'h0021;
		rq <= 8'h05;
		take(1, 4'h4, 16'h34A0);
		`CHK(cpu_priority, 2'h2)
		rq[2] <= 0;
		take(0, 4'h0, 16'h0000);
		rd(8'h9C, 8'h02);
		pv <= 16'h00E1;
		rq[3] <= 1;
		take(1, 4'h5, 16'h3480);
		rd(8'h9C, 8'h0B);
		rq <= 0;
		pop;
		pop;
		`CHK(cpu_priority, 2'h0)
		$display("test priority done");
		rq[0] <= 1;
		@(posedge clk_sys) rq[0] <= 0;
		take(0, 4'h0, 16'h0000);
		$display("test dropped done");
		wr(8'h98, 8'h29);
		porte_bit0 <= 1;
		repeat (6) @(posedge clk_sys);
		rd(8'h9D, 8'h01);
		porte_bit4 <= 1;
		repeat (6) @(posedge clk_sys);
		rd(8'h9D, 8'h05);
		take(1, 4'h1, 16'h1200);
		rd(8'h9D, 8'h00);
		take(0, 4'h0, 16'h0000);
		pop;
		wr(8'h99, 8'h16);
		porte_bit1 <= 0;
		repeat (6) @(posedge clk_sys);
		take(1, 4'h0, 16'h1210);
		`CHK(cpu_priority, 2'h2)
		pop;
		$display("test external done");
		end_sim;
	end
endmodule
